// File: ckbz_top.sv
`timescale 1ns/1ps
`default_nettype none
module ckbz_top #(
    parameter int CNT_W = ckbz_pkg::CKBZ_CNT_W
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // cpu memory-manipulation port
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_bit,
    input wire logic [2:0] cpu_bit_idx,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_rd,
    output logic [7:0] cpu_rdata,
    // subsystem clock pin
    input wire logic sub_clk,
    // clock output pin
    input wire logic clock_output_pin_in,
    output logic clock_output_pin_out,
    output logic clock_output_pin_oe_n,
    // buzzer pin
    input wire logic buzzer_pin_in,
    output logic buzzer_pin_out,
    output logic buzzer_pin_oe_n
);
    logic [7:0] clock_output_select;
    logic [7:0] port_direction;
    logic [7:0] port_latch;
    logic [2:0] pins_sync;
    logic clk_wave;
    logic clk_running;
    logic bz_wave;
    logic bz_running;

    initial begin
        if (CNT_W < 14) begin
            $error("ckbz_top: CNT_W must be at least 14");
        end
    end

    // address hit, used by every write and read path
    function automatic logic hit(input logic [15:0] a,
                                 input logic [15:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    // merge a byte write or a single-bit write into the old value
    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic bit_op,
                                         input logic [2:0] idx,
                                         input logic [7:0] data);
        logic [7:0] res;
        res = old;
        if (bit_op) begin
            res[idx] = data[0];
        end else begin
            res = data;
        end
        merge = res;
    endfunction

    // write decode
    wire wr_select = cpu_wr & hit(cpu_addr, ckbz_pkg::CKBZ_ADDR_SELECT);
    wire wr_direction = cpu_wr & hit(cpu_addr, ckbz_pkg::CKBZ_ADDR_DIRECTION);
    wire wr_latch = cpu_wr & hit(cpu_addr, ckbz_pkg::CKBZ_ADDR_LATCH);

    wire [7:0] next_select =
        merge(clock_output_select, cpu_bit, cpu_bit_idx, cpu_wdata);
    wire [7:0] next_direction =
        merge(port_direction, cpu_bit, cpu_bit_idx, cpu_wdata);
    wire [7:0] next_latch =
        merge(port_latch, cpu_bit, cpu_bit_idx, cpu_wdata);

    // register file
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            clock_output_select <= ckbz_pkg::CKBZ_SELECT_RESET;
            port_direction <= ckbz_pkg::CKBZ_DIRECTION_RESET;
            port_latch <= ckbz_pkg::CKBZ_LATCH_RESET;
        end else begin
            if (wr_select) begin
                clock_output_select <= next_select;
            end
            if (wr_direction) begin
                port_direction <= next_direction;
            end
            if (wr_latch) begin
                port_latch <= next_latch;
            end
        end
    end

    // pin inputs and the subsystem clock cross into mclk here
    ckbz_sync2 #(
        .WIDTH(3)
    ) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in({sub_clk, buzzer_pin_in, clock_output_pin_in}),
        .sync_out(pins_sync)
    );

    // field decode
    wire clk_en = clock_output_select[ckbz_pkg::CKBZ_CLOCK_ENABLE_BIT];
    wire [3:0] clk_src = clock_output_select[
        ckbz_pkg::CKBZ_CLOCK_SOURCE_HI:ckbz_pkg::CKBZ_CLOCK_SOURCE_LO];
    // prohibited codes leave the wave low rather than pick a stray rate
    wire clk_valid = (clk_src <= ckbz_pkg::CKBZ_SOURCE_MAX_DIV);
    wire clk_sub = (clk_src == ckbz_pkg::CKBZ_SOURCE_SUB);
    wire bz_en = clock_output_select[ckbz_pkg::CKBZ_BUZZER_ENABLE_BIT];
    wire [1:0] bz_code = clock_output_select[
        ckbz_pkg::CKBZ_BUZZER_FREQ_HI:ckbz_pkg::CKBZ_BUZZER_FREQ_LO];
    wire [3:0] bz_sel = ckbz_pkg::CKBZ_BUZZER_BASE_EXP + {2'b00, bz_code};

    // counter bit n toggles every 2^n cycles: main clock is mclk / 2
    ckbz_divider #(
        .CNT_W(CNT_W)
    ) u_clock_div (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .en(clk_en),
        .sel(clk_src),
        .valid(clk_valid),
        .sub_sel(clk_sub),
        .sub_level(pins_sync[2]),
        .wave(clk_wave),
        .running(clk_running)
    );

    ckbz_divider #(
        .CNT_W(CNT_W)
    ) u_buzzer_div (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .en(bz_en),
        .sel(bz_sel),
        .valid(1'b1),
        .sub_sel(1'b0),
        .sub_level(1'b0),
        .wave(bz_wave),
        .running(bz_running)
    );

    // read mux: a pin in input mode reads its synchronised level
    wire [7:0] pin_view = {port_latch[7:2],
        port_direction[ckbz_pkg::CKBZ_BUZZER_PIN] ? pins_sync[1]
            : port_latch[ckbz_pkg::CKBZ_BUZZER_PIN],
        port_direction[ckbz_pkg::CKBZ_CLOCK_PIN] ? pins_sync[0]
            : port_latch[ckbz_pkg::CKBZ_CLOCK_PIN]};
    wire [7:0] read_value =
        hit(cpu_addr, ckbz_pkg::CKBZ_ADDR_SELECT) ? clock_output_select
        : hit(cpu_addr, ckbz_pkg::CKBZ_ADDR_DIRECTION) ? port_direction
        : hit(cpu_addr, ckbz_pkg::CKBZ_ADDR_LATCH) ? pin_view
        : 8'h00;

    // latch ored with the wave: a set latch would mask the wave
    wire next_clock_pin = port_latch[ckbz_pkg::CKBZ_CLOCK_PIN] | clk_wave;
    wire next_buzzer_pin = port_latch[ckbz_pkg::CKBZ_BUZZER_PIN] | bz_wave;

    // pin and read-data flops
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cpu_rdata <= 8'h00;
            clock_output_pin_out <= 1'b0;
            buzzer_pin_out <= 1'b0;
            clock_output_pin_oe_n <= 1'b1;
            buzzer_pin_oe_n <= 1'b1;
        end else begin
            cpu_rdata <= cpu_rd ? read_value : 8'h00;
            clock_output_pin_out <= next_clock_pin;
            buzzer_pin_out <= next_buzzer_pin;
            clock_output_pin_oe_n <=
                port_direction[ckbz_pkg::CKBZ_CLOCK_PIN];
            buzzer_pin_oe_n <=
                port_direction[ckbz_pkg::CKBZ_BUZZER_PIN];
        end
    end

    // helper: length of the current high phase of each wave
    logic [15:0] clk_high_len;
    logic [15:0] bz_high_len;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            clk_high_len <= 16'h0000;
            bz_high_len <= 16'h0000;
        end else begin
            clk_high_len <= clk_wave ? clk_high_len + 16'h0001 : 16'h0000;
            bz_high_len <= bz_wave ? bz_high_len + 16'h0001 : 16'h0000;
        end
    end

    // helper: low phase length, and whether this run has had a high yet;
    // the first low after a start is one cycle longer and is not judged
    logic [15:0] clk_low_len;
    logic [15:0] bz_low_len;
    logic clk_had_high;
    logic bz_had_high;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            clk_low_len <= 16'h0000;
            bz_low_len <= 16'h0000;
            clk_had_high <= 1'b0;
            bz_had_high <= 1'b0;
        end else begin
            clk_low_len <= clk_wave ? 16'h0000 : clk_low_len + 16'h0001;
            bz_low_len <= bz_wave ? 16'h0000 : bz_low_len + 16'h0001;
            clk_had_high <= clk_running & (clk_had_high | clk_wave);
            bz_had_high <= bz_running & (bz_had_high | bz_wave);
        end
    end

    a_select_reset: assert property (
        @(posedge mclk) sys_rst |=> (clock_output_select == 8'h00)
            && !clk_wave && !bz_wave)
        else $error("select register not cleared by reset");

    a_direction_reset: assert property (
        @(posedge mclk) sys_rst |=> (port_direction == 8'hFF)
            ##1 clock_output_pin_oe_n && buzzer_pin_oe_n)
        else $error("direction register not all ones after reset");

    a_byte_write: assert property (
        @(posedge mclk) disable iff (sys_rst)
        wr_select && !cpu_bit |=> clock_output_select == $past(cpu_wdata))
        else $error("byte write to select register lost");

    a_bit_write: assert property (
        @(posedge mclk) disable iff (sys_rst)
        wr_select && cpu_bit |=>
            clock_output_select[$past(cpu_bit_idx)] == $past(cpu_wdata[0]))
        else $error("bit write to select register lost");

    a_buzzer_halt: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !bz_en && !bz_wave && !bz_running |=> !bz_wave[*3])
        else $error("buzzer wave moved while disabled");

    a_clock_halt: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !clk_en && !clk_wave && !clk_running |=> !clk_wave[*3])
        else $error("clock wave moved while disabled");

    a_buzzer_rate: assert property (
        @(posedge mclk) disable iff (sys_rst)
        $fell(bz_wave) && $stable(bz_code) |->
            $past(bz_high_len) + 16'h0001 == (16'h0001 << bz_sel))
        else $error("buzzer high phase has wrong length");

    a_clock_rate: assert property (
        @(posedge mclk) disable iff (sys_rst)
        $fell(clk_wave) && clk_valid && $stable(clk_src) |->
            $past(clk_high_len) + 16'h0001 == (16'h0001 << clk_src))
        else $error("clock high phase has wrong length");

    a_clock_start: assert property (
        @(posedge mclk) disable iff (sys_rst)
        $rose(clk_running) |-> !clk_wave ##1 !clk_wave)
        else $error("clock output started in a high phase");

    a_clock_stop: assert property (
        @(posedge mclk) disable iff (sys_rst)
        clk_wave && !clk_en |-> clk_running)
        else $error("clock output cut during a high phase");

    a_pin_buffer: assert property (
        @(posedge mclk) disable iff (sys_rst)
        wr_direction && !cpu_bit ##1 !wr_direction |=>
            clock_output_pin_oe_n == $past(cpu_wdata[0], 2))
        else $error("pin buffer does not follow direction bit");

    a_oe_follow: assert property (
        @(posedge mclk) disable iff (sys_rst)
        1'b1 |=> buzzer_pin_oe_n ==
            $past(port_direction[ckbz_pkg::CKBZ_BUZZER_PIN]))
        else $error("buzzer pin buffer does not follow direction bit");

    a_clock_square: assert property (
        @(posedge mclk) disable iff (sys_rst)
        $rose(clk_wave) && clk_had_high && clk_valid && $stable(clk_src) |->
            $past(clk_low_len) + 16'h0001 == (16'h0001 << clk_src))
        else $error("clock low phase differs from its high phase");

    a_buzzer_square: assert property (
        @(posedge mclk) disable iff (sys_rst)
        $rose(bz_wave) && bz_had_high && $stable(bz_code) |->
            $past(bz_low_len) + 16'h0001 == (16'h0001 << bz_sel))
        else $error("buzzer low phase differs from its high phase");

    // a stopped divider with a clear latch must leave the pin low
    a_clock_pin_low: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !clk_en && !clk_running && !port_latch[ckbz_pkg::CKBZ_CLOCK_PIN] |=>
            !clock_output_pin_out)
        else $error("clock pin not low while disabled");

    a_buzzer_pin_low: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !bz_en && !bz_running && !port_latch[ckbz_pkg::CKBZ_BUZZER_PIN] |=>
            !buzzer_pin_out)
        else $error("buzzer pin not low while disabled");
endmodule
`default_nettype wire

// File: ckbz_pkg.sv
package ckbz_pkg;
    // register map of the cpu memory-manipulation port
    localparam logic [15:0] CKBZ_ADDR_SELECT = 16'hFF40;
    localparam logic [15:0] CKBZ_ADDR_DIRECTION = 16'hFF2E;
    localparam logic [15:0] CKBZ_ADDR_LATCH = 16'hFF0E;

    // reset values
    localparam logic [7:0] CKBZ_SELECT_RESET = 8'h00;
    localparam logic [7:0] CKBZ_DIRECTION_RESET = 8'hFF;
    localparam logic [7:0] CKBZ_LATCH_RESET = 8'h00;

    // field positions of the clock output select register
    localparam int CKBZ_BUZZER_ENABLE_BIT = 7;
    localparam int CKBZ_BUZZER_FREQ_HI = 6;
    localparam int CKBZ_BUZZER_FREQ_LO = 5;
    localparam int CKBZ_CLOCK_ENABLE_BIT = 4;
    localparam int CKBZ_CLOCK_SOURCE_HI = 3;
    localparam int CKBZ_CLOCK_SOURCE_LO = 0;

    // pin positions in the port direction and latch registers
    localparam int CKBZ_CLOCK_PIN = 0;
    localparam int CKBZ_BUZZER_PIN = 1;

    // clock source codes: 0..7 main clock / 2^n, 8 subsystem clock
    localparam logic [3:0] CKBZ_SOURCE_MAX_DIV = 4'h7;
    localparam logic [3:0] CKBZ_SOURCE_SUB = 4'h8;

    // buzzer divider exponent for code 00
    localparam logic [3:0] CKBZ_BUZZER_BASE_EXP = 4'hA;

    // divider counter width, enough for the 2^13 buzzer rate
    localparam int CKBZ_CNT_W = 14;
endpackage

// File: ckbz_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module ckbz_sync2 #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // stage1 feeds only the second flop
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule
`default_nettype wire

// File: ckbz_divider.sv
`timescale 1ns/1ps
`default_nettype none
module ckbz_divider #(
    parameter int CNT_W = ckbz_pkg::CKBZ_CNT_W
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // control
    input wire logic en,
    input wire logic [3:0] sel,
    input wire logic valid,
    input wire logic sub_sel,
    input wire logic sub_level,
    // output wave and run state
    output logic wave,
    output logic running
);
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic src;
    logic next_running;

    initial begin
        if (CNT_W < 14) begin
            $error("ckbz_divider: CNT_W must be at least 14");
        end
    end

    // stopped divider is held at zero, so a start is in the low phase
    assign next_cnt = running ? cnt + 1'b1 : '0;
    assign src = sub_sel ? sub_level : (valid ? cnt[sel] : 1'b0);
    // start only while low; stop only once any high phase has ended
    assign next_running = running ? (en | src) : (en & ~src);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt <= '0;
            running <= 1'b0;
            wave <= 1'b0;
        end else begin
            cnt <= next_cnt;
            running <= next_running;
            wave <= running & src;
        end
    end
endmodule
`default_nettype wire

// File: ckbz_partner.sv
`timescale 1ns/1ps
`default_nettype none
module ckbz_partner #(
    parameter real SUB_HALF_NS = 15259.0
) (
    // pin drive from the block
    input wire logic clk_out,
    input wire logic clk_oe_n,
    input wire logic bz_out,
    input wire logic bz_oe_n,
    // levels seen by the block
    output logic sub_clk,
    output logic clk_pin,
    output logic bz_pin
);
    // watch crystal runs free, unrelated in phase to mclk
    initial sub_clk = 1'b0;
    always #(SUB_HALF_NS) sub_clk = ~sub_clk;
    // board pull-downs hold a released pin low
    assign clk_pin = clk_oe_n ? 1'b0 : clk_out;
    assign bz_pin = bz_oe_n ? 1'b0 : bz_out;
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] cpu_addr = 16'h0000;
    logic cpu_wr = 1'b0;
    logic cpu_bit = 1'b0;
    logic [2:0] cpu_bit_idx = 3'h0;
    logic [7:0] cpu_wdata = 8'h00;
    logic cpu_rd = 1'b0;
    logic [7:0] cpu_rdata;
    logic sub_clk, clk_in, clk_out, clk_oe_n, bz_in, bz_out, bz_oe_n;
    int failures = 0;
    int total_checks = 0;
    localparam logic [15:0] SEL = ckbz_pkg::CKBZ_ADDR_SELECT;
    localparam logic [15:0] DIR = ckbz_pkg::CKBZ_ADDR_DIRECTION;

    always #25 mclk = ~mclk;

    ckbz_top ckbz_top_i (
        .mclk(mclk), .sys_rst(sys_rst), .cpu_addr(cpu_addr),
        .cpu_wr(cpu_wr), .cpu_bit(cpu_bit), .cpu_bit_idx(cpu_bit_idx),
        .cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
        .sub_clk(sub_clk), .clock_output_pin_in(clk_in),
        .clock_output_pin_out(clk_out), .clock_output_pin_oe_n(clk_oe_n),
        .buzzer_pin_in(bz_in), .buzzer_pin_out(bz_out),
        .buzzer_pin_oe_n(bz_oe_n)
    );
    ckbz_partner ckbz_partner_i (
        .clk_out(clk_out), .clk_oe_n(clk_oe_n), .bz_out(bz_out),
        .bz_oe_n(bz_oe_n), .sub_clk(sub_clk), .clk_pin(clk_in),
        .bz_pin(bz_in)
    );

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic b,
                      input logic [2:0] i, input logic [7:0] d);
        @(posedge mclk);
        cpu_addr <= a;
        cpu_bit <= b;
        cpu_bit_idx <= i;
        cpu_wdata <= d;
        cpu_wr <= 1'b1;
        @(posedge mclk);
        cpu_wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge mclk);
        cpu_addr <= a;
        cpu_rd <= 1'b1;
        @(posedge mclk);
        cpu_rd <= 1'b0;
        @(negedge mclk);
        check("read data", {8'h00, cpu_rdata}, {8'h00, exp});
    endtask

    function automatic logic pin(input bit bz);
        return bz ? bz_out : clk_out;
    endfunction

    // waits for a high phase, then counts its length in mclk cycles
    task automatic meas(input bit bz, output int hi);
        int n;
        n = 0;
        hi = 0;
        while (pin(bz) !== 1'b1 && n < 40000) begin
            @(negedge mclk);
            n++;
        end
        while (pin(bz) === 1'b1 && hi < 20000) begin
            @(negedge mclk);
            hi++;
        end
    endtask

    task automatic t_reset();
        rd(SEL, ckbz_pkg::CKBZ_SELECT_RESET);
        rd(DIR, ckbz_pkg::CKBZ_DIRECTION_RESET);
        rd(ckbz_pkg::CKBZ_ADDR_LATCH, 8'h00);
        rd(16'h0000, 8'h00);
        check("pin oe", {14'h0, clk_oe_n, bz_oe_n}, 16'h3);
        check("pin out", {14'h0, clk_out, bz_out}, 16'h0);
        wr(DIR, 1'b0, 3'h0, 8'hFE);
        repeat (2) @(negedge mclk);
        check("oe byte", {14'h0, clk_oe_n, bz_oe_n}, 16'h1);
        wr(DIR, 1'b0, 3'h0, 8'hFF);
        repeat (2) @(negedge mclk);
        check("oe back", {14'h0, clk_oe_n, bz_oe_n}, 16'h3);
        $display("test reset done");
    endtask

    task automatic t_clock();
        int hi;
        wr(DIR, 1'b1, 3'h0, 8'h00);
        wr(DIR, 1'b1, 3'h1, 8'h00);
        repeat (2) @(negedge mclk);
        check("oe on", {14'h0, clk_oe_n, bz_oe_n}, 16'h0);
        for (int n = 0; n < 8; n++) begin
            wr(SEL, 1'b0, 3'h0, 8'(n));
            repeat (20) @(negedge mclk);
            check("clock idle", {15'h0, clk_out}, 16'h0);
            wr(SEL, 1'b1, 3'h4, 8'h01);
            meas(1'b0, hi);
            check("first high", 16'(hi), 16'(1 << n));
            meas(1'b0, hi);
            check("clock high", 16'(hi), 16'(1 << n));
            wr(SEL, 1'b1, 3'h4, 8'h00);
            repeat (300) @(negedge mclk);
        end
        rd(SEL, 8'h07);
        $display("test clock codes done");
    endtask

    task automatic t_stop();
        int hi;
        wr(SEL, 1'b0, 3'h0, 8'h03);
        wr(SEL, 1'b1, 3'h4, 8'h01);
        meas(1'b0, hi);
        while (clk_out !== 1'b1) @(negedge mclk);
        fork
            wr(SEL, 1'b1, 3'h4, 8'h00);
        join_none
        meas(1'b0, hi);
        check("last high", 16'(hi), 16'h8);
        repeat (40) begin
            @(negedge mclk);
            check("stopped", {15'h0, clk_out}, 16'h0);
        end
        wr(SEL, 1'b0, 3'h0, 8'h08);
        wr(SEL, 1'b1, 3'h4, 8'h01);
        meas(1'b0, hi);
        check("sub clock", 16'(hi > 295 && hi < 315), 16'h1);
        wr(SEL, 1'b1, 3'h4, 8'h00);
        // let the last sub clock high phase finish before the next test
        repeat (400) @(negedge mclk);
        check("sub stopped", {15'h0, clk_out}, 16'h0);
        $display("test stop and sub clock done");
    endtask

    task automatic t_buzzer();
        int hi;
        for (int c = 0; c < 4; c++) begin
            wr(SEL, 1'b0, 3'h0, 8'(c << 5));
            repeat (20) @(negedge mclk);
            check("buzzer idle", {15'h0, bz_out}, 16'h0);
            wr(SEL, 1'b1, 3'h7, 8'h01);
            meas(1'b1, hi);
            check("buzzer high", 16'(hi), 16'(1024 << c));
            meas(1'b1, hi);
            check("buzzer again", 16'(hi), 16'(1024 << c));
            check("clock quiet", {15'h0, clk_out}, 16'h0);
            wr(SEL, 1'b1, 3'h7, 8'h00);
            repeat (2000) @(negedge mclk);
            check("buzzer off", {15'h0, bz_out}, 16'h0);
        end
        $display("test buzzer done");
    endtask

    initial begin
        #6000000;
        failures++;
        $display("CHECK FAILED watchdog expected done seen hang");
        end_sim();
    end

    initial begin
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        t_reset();
        t_clock();
        t_stop();
        t_buzzer();
        end_sim();
    end
endmodule
`default_nettype wire
